// ### verilog/ivm_pkg.sv
package ivm_pkg;

	// Source population and widths
	localparam int NUM_SRC  = 24;
	localparam int NUM_MASK = 21;
	localparam int NUM_PINS = 7;
	localparam int IDX_W    = 5;

	// Maskable slot index equals its default priority
	localparam int SRC_WDT  = 0;
	localparam int SRC_PIN0 = 1;
	localparam int SRC_CSI0 = 8;
	localparam int SRC_CSI1 = 9;
	localparam int SRC_SER  = 10;
	localparam int SRC_SR   = 11;
	localparam int SRC_ST   = 12;
	localparam int SRC_WT   = 13;
	localparam int SRC_TM00 = 14;
	localparam int SRC_TM01 = 15;
	localparam int SRC_TM1  = 16;
	localparam int SRC_TM2  = 17;
	localparam int SRC_AD   = 18;
	localparam int SRC_TM5  = 19;
	localparam int SRC_TM6  = 20;

	// Vector table addresses
	localparam logic [15:0] VEC_NMI  = 16'h0004;
	localparam logic [15:0] VEC_TRAP = 16'h003E;
	localparam logic [15:0] VEC_BASE = 16'h0004;

	// Register byte offsets
	localparam logic [11:0] ADDR_FLAG = 12'h000;
	localparam logic [11:0] ADDR_MASK = 12'h004;
	localparam logic [11:0] ADDR_PRIO = 12'h008;
	localparam logic [11:0] ADDR_CTRL = 12'h00C;
	localparam logic [11:0] ADDR_EDGE = 12'h010;
	localparam logic [11:0] ADDR_STAT = 12'h014;

	// Values after reset
	localparam logic [20:0] RST_FLAG = 21'h000000;
	localparam logic [20:0] RST_MASK = 21'h1FFFFF;
	localparam logic [20:0] RST_PRIO = 21'h1FFFFF;
	localparam logic        RST_CTRL = 1'b0;
	localparam logic [13:0] RST_EDGE = 14'h0000;

	// Pin 0 noise filter length in cycles
	localparam int PIN0_FILT_LEN = 3;

	// Edge select codes, two bits per pin
	localparam logic [1:0] EDGE_FALL = 2'b00;
	localparam logic [1:0] EDGE_RISE = 2'b01;
	localparam logic [1:0] EDGE_NONE = 2'b10;
	localparam logic [1:0] EDGE_BOTH = 2'b11;

	// Class of the presented request, Gray ordered
	typedef enum logic [1:0] {
		CLS_LOW  = 2'b00,
		CLS_HIGH = 2'b01,
		CLS_NMI  = 2'b11,
		CLS_TRAP = 2'b10
	} ivm_cls_type;

endpackage

// ### verilog/ivm_pin_edge.sv
`timescale 1ns/1ps
module ivm_pin_edge
	import ivm_pkg::*;
#(
	parameter int FILT_LEN = 0
) (
	input  wire logic       ref_clk_i,
	input  wire logic       rst_n_i,
	input  wire logic       pin_i,
	input  wire logic [1:0] edge_sel_i,
	output logic            event_o
);

	localparam int CW = (FILT_LEN > 1) ? $clog2(FILT_LEN) : 1;

	typedef struct packed {
		logic          armed;
		logic          lvl;
		logic [CW-1:0] cnt;
		logic          evt;
	} ivm_edge_st_type;

	ivm_edge_st_type st;
	ivm_edge_st_type d;
	logic            rise;
	logic            fall;

	// Filter and edge detect; first cycle after reset only learns the level
	always_comb begin
		d = st;
		if (!st.armed) begin
			d.armed = 1'b1;
			d.lvl = pin_i;
			d.cnt = '0;
		end else if (FILT_LEN <= 1) begin
			d.lvl = pin_i;
		end else if (pin_i == st.lvl) begin
			d.cnt = '0;
		end else if (st.cnt == CW'(FILT_LEN - 1)) begin
			d.lvl = pin_i;
			d.cnt = '0;
		end else begin
			d.cnt = st.cnt + 1'b1;
		end
		rise = st.armed & d.lvl & ~st.lvl;
		fall = st.armed & ~d.lvl & st.lvl;
		case (edge_sel_i)
			EDGE_FALL: d.evt = fall;
			EDGE_RISE: d.evt = rise;
			EDGE_BOTH: d.evt = rise | fall;
			default:   d.evt = 1'b0;
		endcase
	end

	// State register
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st <= '0;
		end else begin
			st <= d;
		end
	end

	assign event_o = st.evt;

endmodule // ivm_pin_edge

// ### verilog/ivm_ctrl.sv
// Behaviour
// - Twenty-four sources across three interrupt categories
// - Fixed default priority, zero highest, twenty lowest
// - Watchdog mode overflow: non-maskable, vector 0004H
// - Interval mode overflow: maskable priority 0
// - Seven pin edges, priorities 1-7, vectors 0006H-0012H
// - Serial 0 and 1 ends: priorities 8, 9
// - Serial 2 receive error: priority 10, 0018H
// - Serial 2 receive and 3-wire share slot 11
// - Serial 2 transmit end: priority 12, 001CH
// - Watch timer interval: priority 13, 001EH
// - 16-bit timer compare matches: priorities 14, 15
// - 8-bit timers 1, 2: priorities 16, 17
// - Conversion complete: priority 18, vector 0028H
// - 8-bit timers 5, 6: priorities 19, 20
// - Pin 0 has its own filtered input
// - Non-maskable ignores enable, outranks everything
// - Group flag splits high and low; high preempts
// - Flags set on event, cleared on acknowledge
// - Software trap accepted regardless of enable
//
// Decided for this implementation: the register addresses and the APB slave port.
`timescale 1ns/1ps
module ivm_ctrl
	import ivm_pkg::*;
#(
	parameter int PIN0_FILT = PIN0_FILT_LEN
) (
	input  wire logic        ref_clk_i,
	input  wire logic        rst_n_i,
	input  wire logic [11:0] paddr_i,
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [31:0] pwdata_i,
	output logic [31:0]      prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	input  wire logic        watchdog_overflow_irq_i,
	input  wire logic [6:0]  ext_pin_irq_i,
	input  wire logic        serial0_done_irq_i,
	input  wire logic        serial1_done_irq_i,
	input  wire logic        serial2_rx_error_irq_i,
	input  wire logic        serial2_rx_done_irq_i,
	input  wire logic        serial2_3wire_done_irq_i,
	input  wire logic        serial2_tx_done_irq_i,
	input  wire logic        watch_interval_irq_i,
	input  wire logic        timer16_match_a_irq_i,
	input  wire logic        timer16_match_b_irq_i,
	input  wire logic        timer8_1_match_irq_i,
	input  wire logic        timer8_2_match_irq_i,
	input  wire logic        adc_done_irq_i,
	input  wire logic        timer8_5_match_irq_i,
	input  wire logic        timer8_6_match_irq_i,
	input  wire logic        software_trap_instr_i,
	input  wire logic        global_irq_enable_i,
	input  wire logic        in_service_priority_flag_i,
	input  wire logic        irq_ack_i,
	output logic             irq_req_o,
	output ivm_cls_type      irq_class_o,
	output logic [15:0]      irq_vector_o,
	output logic             standby_release_o
);

	typedef struct packed {
		logic [20:0] if_q;
		logic [20:0] mk_q;
		logic [20:0] pr_q;
		logic        wdt_interval_q;
		logic [13:0] edge_q;
		logic        nmi_q;
		logic        trap_q;
		logic        irq_q;
		ivm_cls_type cls_q;
		logic [IDX_W-1:0] idx_q;
		logic [15:0] vec_q;
		logic        stby_q;
		logic [31:0] rdata_q;
	} ivm_state_type;

	ivm_state_type    st;
	ivm_state_type    d;
	logic [6:0]       ext_evt;
	logic [20:0]      ev;
	logic [20:0]      elig;
	logic [20:0]      hi;
	logic [20:0]      lo;
	logic [20:0]      sel;
	logic             hit;
	logic [IDX_W-1:0] idx;
	logic             mapped;
	logic             acc_wr;
	logic             ack_mask;
	logic [31:0]      rd_mux;

	// Pin 0 gets a noise filter; the other six see plain edges
	for (genvar g = 0; g < NUM_PINS; g++) begin : g_pin
		ivm_pin_edge #(
			.FILT_LEN ((g == 0) ? PIN0_FILT : 0)
		) u_edge (
			.ref_clk_i  (ref_clk_i),
			.rst_n_i    (rst_n_i),
			.pin_i      (ext_pin_irq_i[g]),
			.edge_sel_i (st.edge_q[2*g+1 -: 2]),
			.event_o    (ext_evt[g])
		);
	end

	// Event vector; slot index is the default priority
	always_comb begin
		ev = '0;
		ev[SRC_WDT] = watchdog_overflow_irq_i & st.wdt_interval_q;
		ev[7:1] = ext_evt;
		ev[SRC_CSI0] = serial0_done_irq_i;
		ev[SRC_CSI1] = serial1_done_irq_i;
		ev[SRC_SER] = serial2_rx_error_irq_i;
		ev[SRC_SR] = serial2_rx_done_irq_i | serial2_3wire_done_irq_i;
		ev[SRC_ST] = serial2_tx_done_irq_i;
		ev[SRC_WT] = watch_interval_irq_i;
		ev[SRC_TM00] = timer16_match_a_irq_i;
		ev[SRC_TM01] = timer16_match_b_irq_i;
		ev[SRC_TM1] = timer8_1_match_irq_i;
		ev[SRC_TM2] = timer8_2_match_irq_i;
		ev[SRC_AD] = adc_done_irq_i;
		ev[SRC_TM5] = timer8_5_match_irq_i;
		ev[SRC_TM6] = timer8_6_match_irq_i;
	end

	// Address decode; zero wait states, so pready is constant
	always_comb begin
		mapped = 1'b0;
		case (paddr_i)
			ADDR_FLAG, ADDR_MASK, ADDR_PRIO,
			ADDR_CTRL, ADDR_EDGE, ADDR_STAT: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
		acc_wr = psel_i & penable_i & pwrite_i & mapped;
		rd_mux = '0;
		case (paddr_i)
			ADDR_FLAG: rd_mux = {11'h000, st.if_q};
			ADDR_MASK: rd_mux = {11'h000, st.mk_q};
			ADDR_PRIO: rd_mux = {11'h000, st.pr_q};
			ADDR_CTRL: rd_mux = {31'h00000000, st.wdt_interval_q};
			ADDR_EDGE: rd_mux = {18'h00000, st.edge_q};
			ADDR_STAT: rd_mux = {18'h00000, st.nmi_q, st.trap_q, st.stby_q, st.irq_q,
				st.cls_q, st.idx_q, 1'b0, global_irq_enable_i, in_service_priority_flag_i};
			default:   rd_mux = '0;
		endcase
	end

	// Next state: flags, registers and the presented winner
	always_comb begin
		d = st;
		ack_mask = irq_ack_i & st.irq_q & ~st.cls_q[1];
		// Read data is captured in the setup cycle so prdata leaves a flop
		if (psel_i && !penable_i && !pwrite_i) begin
			d.rdata_q = rd_mux;
		end
		if (acc_wr) begin
			case (paddr_i)
				ADDR_FLAG: d.if_q = pwdata_i[20:0];
				ADDR_MASK: d.mk_q = pwdata_i[20:0];
				ADDR_PRIO: d.pr_q = pwdata_i[20:0];
				ADDR_CTRL: d.wdt_interval_q = pwdata_i[0];
				ADDR_EDGE: d.edge_q = pwdata_i[13:0];
				default:   d.edge_q = st.edge_q;
			endcase
		end
		// Acknowledge clears only the source that was presented
		if (ack_mask) begin
			d.if_q[st.idx_q] = 1'b0;
		end
		// Set last so a coincident event beats a clear
		d.if_q = d.if_q | ev;
		d.nmi_q = (st.nmi_q & ~(irq_ack_i & st.irq_q & (st.cls_q == CLS_NMI)))
			| (watchdog_overflow_irq_i & ~st.wdt_interval_q);
		d.trap_q = (st.trap_q & ~(irq_ack_i & st.irq_q & (st.cls_q == CLS_TRAP)))
			| software_trap_instr_i;
		// A high-group service in progress blocks all maskable requests
		elig = d.if_q & ~d.mk_q & {21{global_irq_enable_i & ~in_service_priority_flag_i}};
		hi = elig & ~d.pr_q;
		lo = elig & d.pr_q;
		sel = (|hi) ? hi : lo;
		hit = 1'b0;
		idx = '0;
		// Downward scan leaves the lowest set index, the highest priority
		for (int i = NUM_MASK - 1; i >= 0; i--) begin
			if (sel[i]) begin
				hit = 1'b1;
				idx = IDX_W'(i);
			end
		end
		// Arbitration uses next-state flags, so an acked source never repeats
		d.irq_q = d.nmi_q | d.trap_q | hit;
		d.idx_q = idx;
		if (d.nmi_q) begin
			d.cls_q = CLS_NMI;
			d.vec_q = VEC_NMI;
		end else if (d.trap_q) begin
			d.cls_q = CLS_TRAP;
			d.vec_q = VEC_TRAP;
		end else if (hit) begin
			d.cls_q = (|hi) ? CLS_HIGH : CLS_LOW;
			d.vec_q = 16'(VEC_BASE + (16'(idx) << 1));
		end else begin
			d.cls_q = CLS_LOW;
			d.vec_q = '0;
		end
		// Wake-up ignores enable and group, only the mask matters
		d.stby_q = d.nmi_q | |(d.if_q & ~d.mk_q);
	end

	// State register
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st <= '0;
			st.mk_q <= RST_MASK;
			st.pr_q <= RST_PRIO;
			st.if_q <= RST_FLAG;
			st.wdt_interval_q <= RST_CTRL;
			st.edge_q <= RST_EDGE;
			st.cls_q <= CLS_LOW;
		end else begin
			st <= d;
		end
	end

	// Outputs; the source count is fixed by the slot layout
	assign pready_o = 1'b1;
	assign pslverr_o = psel_i & penable_i & ~mapped;
	assign prdata_o = st.rdata_q;
	assign irq_req_o = st.irq_q;
	assign irq_class_o = st.cls_q;
	assign irq_vector_o = st.vec_q;
	assign standby_release_o = st.stby_q;

	// Slots plus the two vectors outside them
	localparam int SRC_TOTAL = NUM_MASK + 2;

	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!rst_n_i);

	property p_src_count;
		1'b1 |-> (SRC_TOTAL + 1 == NUM_SRC);
	endproperty
	a_src_count: assert property (p_src_count)
		else $error("source count differs from slot layout");

	property p_nmi_top;
		$rose(st.nmi_q) |-> irq_req_o && irq_class_o == CLS_NMI && irq_vector_o == VEC_NMI;
	endproperty
	a_nmi_top: assert property (p_nmi_top)
		else $error("non-maskable request not presented on top");

	property p_wdt_nmi;
		watchdog_overflow_irq_i && !st.wdt_interval_q |=> st.nmi_q && !$past(ev[SRC_WDT]);
	endproperty
	a_wdt_nmi: assert property (p_wdt_nmi)
		else $error("watchdog overflow did not raise non-maskable");

	property p_wdt_int;
		watchdog_overflow_irq_i && st.wdt_interval_q |=> st.if_q[SRC_WDT] && !st.nmi_q;
	endproperty
	a_wdt_int: assert property (p_wdt_int)
		else $error("interval overflow did not set slot zero");

	property p_pin_flag;
		(|ext_evt) |=> ((st.if_q[7:1] & $past(ext_evt)) == $past(ext_evt));
	endproperty
	a_pin_flag: assert property (p_pin_flag)
		else $error("pin event did not set its flag");

	property p_shared_slot;
		serial2_rx_done_irq_i || serial2_3wire_done_irq_i |=> st.if_q[SRC_SR];
	endproperty
	a_shared_slot: assert property (p_shared_slot)
		else $error("serial 2 receive or 3-wire end lost");

	property p_ack_clear;
		irq_ack_i && irq_req_o && !irq_class_o[1] && !ev[st.idx_q]
			|=> !st.if_q[$past(st.idx_q)];
	endproperty
	a_ack_clear: assert property (p_ack_clear)
		else $error("acknowledged flag not cleared");

	property p_trap;
		$rose(st.trap_q) && !st.nmi_q |-> irq_req_o && irq_class_o == CLS_TRAP
			&& irq_vector_o == VEC_TRAP;
	endproperty
	a_trap: assert property (p_trap)
		else $error("software trap not presented");

	property p_vec_map;
		irq_req_o && !irq_class_o[1] |-> irq_vector_o == 16'(VEC_BASE + (16'(st.idx_q) << 1));
	endproperty
	a_vec_map: assert property (p_vec_map)
		else $error("vector does not match slot");

	property p_gate;
		irq_req_o && !irq_class_o[1] |-> $past(global_irq_enable_i)
			&& !$past(in_service_priority_flag_i) && !st.mk_q[st.idx_q];
	endproperty
	a_gate: assert property (p_gate)
		else $error("masked or disabled request presented");

	property p_group;
		irq_req_o && irq_class_o == CLS_LOW |-> $past(hi) == '0;
	endproperty
	a_group: assert property (p_group)
		else $error("low group won over pending high group");

	property p_lowest;
		irq_req_o && !irq_class_o[1]
			|-> ($past(sel) & ((21'h000001 << st.idx_q) - 21'h000001)) == '0;
	endproperty
	a_lowest: assert property (p_lowest)
		else $error("a higher default priority was skipped");

	c_nmi: cover property (irq_ack_i && irq_req_o && irq_class_o == CLS_NMI);
	c_trap: cover property (irq_ack_i && irq_req_o && irq_class_o == CLS_TRAP);
	c_high: cover property (irq_ack_i && irq_req_o && irq_class_o == CLS_HIGH);
	c_pin0: cover property (ext_evt[0]);
	c_low: cover property (irq_ack_i && irq_req_o && irq_class_o == CLS_LOW);

	// A pending non-maskable request owns the outputs every cycle
	property p_nmi_first;
		st.nmi_q |-> irq_req_o && irq_class_o == CLS_NMI;
	endproperty
	a_nmi_first: assert property (p_nmi_first)
		else $error("non-maskable pending but not presented");

	// Idle outputs are quiet so the CPU never fetches a stale vector
	property p_idle_quiet;
		!irq_req_o |-> irq_vector_o == 16'h0000 && irq_class_o == CLS_LOW;
	endproperty
	a_idle_quiet: assert property (p_idle_quiet)
		else $error("vector shown without a request");

	property p_nmi_ack;
		irq_ack_i && irq_req_o && irq_class_o == CLS_NMI && !watchdog_overflow_irq_i
			|=> !st.nmi_q;
	endproperty
	a_nmi_ack: assert property (p_nmi_ack)
		else $error("non-maskable not cleared by acknowledge");

	property p_trap_ack;
		irq_ack_i && irq_req_o && irq_class_o == CLS_TRAP && !software_trap_instr_i
			|=> !st.trap_q;
	endproperty
	a_trap_ack: assert property (p_trap_ack)
		else $error("software trap not cleared by acknowledge");

endmodule // ivm_ctrl

// ### bench/ivm_cpu_model.sv
`timescale 1ns/1ps
// CPU side: acknowledges whatever request is presented, promptly or after a few idle cycles
module ivm_cpu_model
	import ivm_pkg::*;
(
	input  wire logic ref_clk_i,
	input  wire logic rst_n_i,
	input  wire logic ack_en_i,
	input  wire logic slow_i,
	input  wire logic irq_req_i,
	output logic      irq_ack_o
);
	logic [1:0] wait_q;

	// One-cycle ack, never two in a row, so a stale request is never acknowledged twice
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			irq_ack_o <= 1'b0;
			wait_q    <= 2'h0;
		end else if (irq_ack_o) begin
			irq_ack_o <= 1'b0;
			wait_q    <= slow_i ? 2'h3 : 2'h0;
		end else if (wait_q != 2'h0) begin
			wait_q <= wait_q - 2'h1;
		end else begin
			irq_ack_o <= ack_en_i & irq_req_i;
		end
	end
endmodule // ivm_cpu_model

// ### bench/tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin fail_count++; \
	$display("mismatch t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb
	import ivm_pkg::*;
;
	logic        ref_clk_i, rst_n_i, psel, penable, pwrite, trap, gie, in_service_priority_flag, ack_en, slow, ev3w;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd, seed;
	logic        pready, pslverr, err, irq_req, irq_ack, stby;
	logic [6:0]  pins;
	logic [20:0] ev, pend, msk, pr;
	ivm_cls_type irq_cls;
	logic [15:0] irq_vec;
	logic [17:0] log_q[$], exp_q[$];
	int          fail_count, n_compared;

	ivm_ctrl #(.PIN0_FILT(2)) uut (
		.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .paddr_i(paddr), .psel_i(psel),
		.penable_i(penable), .pwrite_i(pwrite), .pwdata_i(pwdata), .prdata_o(prdata),
		.pready_o(pready), .pslverr_o(pslverr), .watchdog_overflow_irq_i(ev[0]),
		.ext_pin_irq_i(pins), .serial0_done_irq_i(ev[8]), .serial1_done_irq_i(ev[9]),
		.serial2_rx_error_irq_i(ev[10]), .serial2_rx_done_irq_i(ev[11]),
		.serial2_3wire_done_irq_i(ev3w), .serial2_tx_done_irq_i(ev[12]),
		.watch_interval_irq_i(ev[13]), .timer16_match_a_irq_i(ev[14]),
		.timer16_match_b_irq_i(ev[15]), .timer8_1_match_irq_i(ev[16]),
		.timer8_2_match_irq_i(ev[17]), .adc_done_irq_i(ev[18]),
		.timer8_5_match_irq_i(ev[19]), .timer8_6_match_irq_i(ev[20]),
		.software_trap_instr_i(trap), .global_irq_enable_i(gie),
		.in_service_priority_flag_i(in_service_priority_flag), .irq_ack_i(irq_ack), .irq_req_o(irq_req),
		.irq_class_o(irq_cls), .irq_vector_o(irq_vec), .standby_release_o(stby));

	ivm_cpu_model u_cpu (
		.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .ack_en_i(ack_en), .slow_i(slow),
		.irq_req_i(irq_req), .irq_ack_o(irq_ack));

	// Clock at 40 MHz
	initial begin
		ref_clk_i = 1'b0;
		forever #12.5 ref_clk_i = ~ref_clk_i;
	end

	// What the CPU got at each acknowledging edge
	always @(posedge ref_clk_i) begin
		if (rst_n_i && irq_ack === 1'b1) log_q.push_back({irq_cls, irq_vec});
	end

	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction

	task automatic results();
		if (fail_count == 0 && n_compared > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask

	// One APB transfer; holds the request until pready is seen at a rising edge, giving up after 20 edges
	task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
		int n;
		@(posedge ref_clk_i);
		psel <= 1'b1; penable <= 1'b0; paddr <= a; pwrite <= w; pwdata <= d;
		@(posedge ref_clk_i);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge ref_clk_i);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0; penable <= 1'b0;
	endtask

	// Let the CPU take every request and compare against the expected order
	task automatic drain();
		int n;
		log_q.delete();
		seed = xs(seed);
		slow <= seed[0];
		ack_en <= 1'b1;
		for (n = 0; n < 300 && log_q.size() < exp_q.size(); n++) @(posedge ref_clk_i);
		repeat (8) @(posedge ref_clk_i);
		ack_en <= 1'b0;
		`CHK(log_q.size(), exp_q.size())
		foreach (exp_q[i]) if (i < log_q.size()) `CHK(log_q[i], exp_q[i])
	endtask

	initial begin
		#(25ns * 20000);
		fail_count++;
		results();
	end

	initial begin
		{psel, penable, pwrite, trap, gie, in_service_priority_flag, ack_en, slow, ev3w} = '0;
		{paddr, pwdata, ev} = '0;
		pins = 7'h7F;
		rst_n_i = 1'b0;
		seed = 32'hA2CB58E7;
		repeat (20) @(posedge ref_clk_i);
		rst_n_i <= 1'b1;
		// Values after reset, then an unmapped place
		apb(ADDR_FLAG, 1'b0, 32'h0); `CHK(rd, 32'h0)
		apb(ADDR_MASK, 1'b0, 32'h0); `CHK(rd, 32'h001FFFFF)
		apb(ADDR_PRIO, 1'b0, 32'h0); `CHK(rd, 32'h001FFFFF)
		apb(ADDR_CTRL, 1'b0, 32'h0); `CHK(rd, 32'h0)
		apb(ADDR_EDGE, 1'b0, 32'h0); `CHK(rd, 32'h0)
		apb(12'h018, 1'b0, 32'h0); `CHK({err, rd}, 33'h100000000)
		// One-cycle glitch: filtered pin 0 ignores it, pin 1 on both edges, pin 2 off
		apb(ADDR_EDGE, 1'b1, 32'h2C);
		apb(ADDR_EDGE, 1'b0, 32'h0); `CHK(rd, 32'h2C)
		@(posedge ref_clk_i) pins <= 7'h78;
		@(posedge ref_clk_i) pins <= 7'h7F;
		repeat (6) @(posedge ref_clk_i);
		apb(ADDR_FLAG, 1'b0, 32'h0); `CHK(rd, 32'h4)
		apb(ADDR_EDGE, 1'b1, 32'h0);
		apb(ADDR_FLAG, 1'b1, 32'h0);
		// Non-maskable and trap with interrupts disabled, both at once
		@(posedge ref_clk_i) begin ev[0] <= 1'b1; trap <= 1'b1; end
		@(posedge ref_clk_i) begin ev[0] <= 1'b0; trap <= 1'b0; end
		exp_q = '{{CLS_NMI, VEC_NMI}, {CLS_TRAP, VEC_TRAP}};
		drain();
		apb(ADDR_FLAG, 1'b0, 32'h0); `CHK(rd, 32'h0)
		apb(ADDR_CTRL, 1'b1, 32'h1);
		// Random pending sets across all maskable slots, first one with every slot pending
		for (int it = 0; it < 5; it++) begin
			seed = xs(seed); pend = (it == 0) ? 21'h1FFFFF : seed[20:0];
			seed = xs(seed); msk = (it == 0) ? 21'h0 : seed[20:0] & seed[30:10];
			seed = xs(seed); pr = seed[20:0];
			apb(ADDR_MASK, 1'b1, {11'h0, msk});
			apb(ADDR_PRIO, 1'b1, {11'h0, pr});
			@(posedge ref_clk_i) begin
				ev <= (pend & 21'h1FF701) | {9'h000, pend[11] & ~seed[31], 11'h000};
				ev3w <= pend[11] & seed[31];
				pins <= ~pend[7:1];
			end
			@(posedge ref_clk_i) begin ev <= '0; ev3w <= 1'b0; end
			repeat (8) @(posedge ref_clk_i);
			apb(ADDR_FLAG, 1'b0, 32'h0); `CHK(rd, {11'h0, pend})
			in_service_priority_flag <= 1'b1; gie <= 1'b1;
			repeat (3) @(posedge ref_clk_i);
			`CHK(irq_req, 1'b0)
			in_service_priority_flag <= 1'b0; gie <= 1'b0;
			repeat (3) @(posedge ref_clk_i);
			`CHK(irq_req, 1'b0)
			gie <= 1'b1;
			exp_q.delete();
			for (int g = 0; g < 2; g++) for (int s = 0; s < 21; s++)
				if (pend[s] && !msk[s] && pr[s] == g)
					exp_q.push_back({g ? CLS_LOW : CLS_HIGH, VEC_BASE + 16'(2 * s)});
			drain();
			apb(ADDR_FLAG, 1'b0, 32'h0); `CHK(rd, {11'h0, pend & msk})
			gie <= 1'b0;
			pins <= 7'h7F;
			apb(ADDR_FLAG, 1'b1, 32'h0);
			repeat (6) @(posedge ref_clk_i);
		end
		results();
	end
endmodule // tb
